// file: core/ome_exec.sv
// execution of or-with-file, move-file and load-literal-to-work
// Notes on behaviour
// - or_work_with_file: W OR file, zero flag updated
// - destination bit 0 to W, 1 to file
// - move_file copies addressed file register unchanged
// - destination bit 0 to W, 1 to file
// - move_file sets zero flag from moved value
// - load_literal_to_work loads low byte, flags untouched
// - literal don't-care bits never affect decode
`timescale 1ns/10ps
`include "ome_consts.svh"

module ome_exec
  import ome_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic instr_valid,
  input wire logic [`OME_WORD_W-1:0] instr,
  input wire logic [`OME_DATA_W-1:0] file_rdata,
  output logic [`OME_DATA_W-1:0] w,
  output logic zero,
  output ome_file_wr_type file_wr,
  output logic done,
  output logic other
);

  function automatic ome_kind_type ome_decode(
    input logic [`OME_WORD_W-1:0] word
  );
    ome_kind_type kind;
    kind = KIND_OTHER;
    if (word[`OME_OPC_MSB:`OME_OPC_LSB] == `OME_OPC_OR) begin
      kind = KIND_OR;
    end else if (word[`OME_OPC_MSB:`OME_OPC_LSB] == `OME_OPC_MOVE) begin
      kind = KIND_MOVE;
    end else if (word[`OME_OPC_MSB:`OME_LIT_OPC_LSB] == `OME_OPC_LIT)
    begin
      // bits 9:8 are not looked at
      kind = KIND_LIT;
    end
    return kind;
  endfunction : ome_decode

  // zero test shared by the datapath and its checks
  function automatic logic ome_is_zero(
    input logic [`OME_DATA_W-1:0] value
  );
    return value == `OME_BYTE_ZERO;
  endfunction : ome_is_zero

  ome_state_type st;
  ome_state_type next_st;
  ome_kind_type kind;
  logic dest_file;
  logic [`OME_DATA_W-1:0] result;

  // decode runs every cycle; instr_valid decides whether it counts
  assign kind = ome_decode(instr);
  assign dest_file = instr[`OME_DEST_BIT];

  // no forwarding: a write-back reaches the caller's file a cycle later
  always_comb begin
    next_st = st;
    next_st.file_wr.en = 1'h0;
    next_st.done = 1'h0;
    next_st.other = 1'h0;
    result = file_rdata;
    if (instr_valid) begin
      // every handled word retires in this one cycle
      next_st.done = (kind != KIND_OTHER);
      next_st.other = (kind == KIND_OTHER);
      case (kind)
        KIND_OR, KIND_MOVE: begin
          if (kind == KIND_OR) begin
            result = st.w | file_rdata;
          end else begin
            result = file_rdata;
          end
          next_st.zero = ome_is_zero(result);
          if (dest_file) begin
            // write back even on a plain move, so it doubles as a test
            next_st.file_wr.en = 1'h1;
            next_st.file_wr.addr = instr[`OME_ADDR_MSB:0];
            next_st.file_wr.data = result;
          end else begin
            next_st.w = result;
          end
        end
        KIND_LIT: begin
          next_st.w = instr[`OME_LIT_MSB:0];
        end
        default: begin
          next_st.other = 1'h1;
        end
      endcase
    end
  end

  // enable low freezes the pulses too, so done may stand for longer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st.w <= `OME_W_RESET;
      st.zero <= `OME_ZERO_RESET;
      st.file_wr.en <= 1'h0;
      st.file_wr.addr <= '0;
      st.file_wr.data <= '0;
      st.done <= 1'h0;
      st.other <= 1'h0;
    end else if (enable) begin
      st <= next_st;
    end
  end

  assign w = st.w;
  assign zero = st.zero;
  assign file_wr = st.file_wr;
  assign done = st.done;
  assign other = st.other;

  // reset cancels any check still waiting for its next edge
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  or_to_work_a: assert property (
    enable && instr_valid && kind == KIND_OR && !dest_file |=>
      w == ($past(st.w) | $past(file_rdata)) &&
      zero == (($past(st.w) | $past(file_rdata)) == `OME_BYTE_ZERO))
    else $error("or to work gave wrong value or flag");

  or_to_file_a: assert property (
    enable && instr_valid && kind == KIND_OR && dest_file |=>
      file_wr.en && file_wr.data == ($past(st.w) | $past(file_rdata)) &&
      file_wr.addr == $past(instr[`OME_ADDR_MSB:0]) && $stable(w))
    else $error("or to file not written back");

  move_to_work_a: assert property (
    enable && instr_valid && kind == KIND_MOVE && !dest_file |=>
      w == $past(file_rdata) && !file_wr.en)
    else $error("move to work wrong");

  move_to_file_a: assert property (
    enable && instr_valid && kind == KIND_MOVE && dest_file |=>
      file_wr.en && file_wr.data == $past(file_rdata) && $stable(w))
    else $error("move to file wrong");

  move_zero_a: assert property (
    enable && instr_valid && kind == KIND_MOVE |=>
      zero == ($past(file_rdata) == `OME_BYTE_ZERO))
    else $error("move zero flag wrong");

  literal_load_a: assert property (
    enable && instr_valid && kind == KIND_LIT |=>
      w == $past(instr[`OME_LIT_MSB:0]) && $stable(zero) && !file_wr.en)
    else $error("literal load wrong");

  // raw opcode bits, so a decode that looked at bits 9:8 would trip this
  literal_dont_care_a: assert property (
    enable && instr_valid &&
      instr[`OME_OPC_MSB:`OME_LIT_OPC_LSB] == `OME_OPC_LIT |=>
      done && !other && w == $past(instr[`OME_LIT_MSB:0]))
    else $error("literal decode depends on don't-care bits");

  or_decode_a: assert property (
    enable && instr_valid &&
      instr[`OME_OPC_MSB:`OME_OPC_LSB] == `OME_OPC_OR |=> done && !other)
    else $error("or word not taken as a handled word");

  move_decode_a: assert property (
    enable && instr_valid &&
      instr[`OME_OPC_MSB:`OME_OPC_LSB] == `OME_OPC_MOVE |=> done && !other)
    else $error("move word not taken as a handled word");

  single_cycle_a: assert property (
    enable && instr_valid && kind != KIND_OTHER |=> done && !other)
    else $error("handled word did not retire in one cycle");

  pulse_drops_a: assert property (
    enable && !instr_valid |=> !done && !other && !file_wr.en)
    else $error("retire or write pulse stood past its cycle");

  idle_holds_a: assert property (
    enable && !instr_valid |=> $stable(w) && $stable(zero))
    else $error("working register or zero flag moved with no word");

  other_no_effect_a: assert property (
    enable && instr_valid && kind == KIND_OTHER |=>
      other && !done && !file_wr.en && $stable(w) && $stable(zero))
    else $error("unhandled word changed state");

  or_file_zero_a: assert property (
    enable && instr_valid && kind == KIND_OR && dest_file |=>
      zero == ome_is_zero($past(st.w) | $past(file_rdata)))
    else $error("or to file left wrong zero flag");

  or_keeps_file_a: assert property (
    enable && instr_valid && kind == KIND_OR && !dest_file |=> !file_wr.en)
    else $error("or to work also wrote the file");

  move_file_addr_a: assert property (
    enable && instr_valid && kind == KIND_MOVE && dest_file |=>
      file_wr.addr == $past(instr[`OME_ADDR_MSB:0]))
    else $error("move to file used wrong address");

  write_only_dest_a: assert property (
    enable && !(instr_valid && dest_file &&
      (kind == KIND_OR || kind == KIND_MOVE)) |=> !file_wr.en)
    else $error("file written without a file destination");

  zero_hold_a: assert property (
    enable && !(instr_valid && (kind == KIND_OR || kind == KIND_MOVE)) |=>
      $stable(zero))
    else $error("zero flag moved without an or or move word");

  frozen_a: assert property (
    !enable |=> $stable(w) && $stable(zero) && $stable(done) &&
      $stable(other) && $stable(file_wr))
    else $error("state moved while clock enable low");

endmodule : ome_exec

// file: core/ome_consts.svh
// constants for the or / move / load-literal execution block
`ifndef OME_CONSTS_SVH
`define OME_CONSTS_SVH

`define OME_WORD_W 14
`define OME_DATA_W 8
`define OME_ADDR_W 7
`define OME_OPC_MSB 13
`define OME_OPC_LSB 8
`define OME_LIT_OPC_LSB 10
`define OME_DEST_BIT 7
`define OME_ADDR_MSB 6
`define OME_LIT_MSB 7
`define OME_OPC_OR 6'h04
`define OME_OPC_MOVE 6'h08
`define OME_OPC_LIT 4'hc
`define OME_LIT_DC_MASK 14'h0300
`define OME_W_RESET 8'h00
`define OME_ZERO_RESET 1'h0
`define OME_BYTE_ZERO 8'h00

`endif

// file: core/ome_pkg.sv
// types shared by the or / move / load-literal execution block
package ome_pkg;
`include "ome_consts.svh"

  typedef enum logic [1:0] {
    KIND_OR,
    KIND_MOVE,
    KIND_LIT,
    KIND_OTHER
  } ome_kind_type;

  typedef struct packed {
    logic en;
    logic [`OME_ADDR_W-1:0] addr;
    logic [`OME_DATA_W-1:0] data;
  } ome_file_wr_type;

  typedef struct packed {
    logic [`OME_DATA_W-1:0] w;
    logic zero;
    ome_file_wr_type file_wr;
    logic done;
    logic other;
  } ome_state_type;

endpackage : ome_pkg

// file: tb/ome_exec_tb_top.sv
// self-checking bench for the or / move / load-literal block
`timescale 1ns/10ps
module ome_exec_tb_top;
  typedef struct packed {
    logic [13:0] i;
    logic [7:0] f;
    logic [7:0] w;
    logic z;
    logic e;
    logic [7:0] d;
    logic dn;
    logic o;
  } ome_row_type;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic enable = 1'h1;
  logic instr_valid = 1'h0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] w;
  logic zero;
  logic done;
  logic other;
  ome_pkg::ome_file_wr_type file_wr;
  int mismatches = 0;
  int tests_run = 0;
  // rows run back to back; all but the move to w (14'h0800) lean on the w or zero left before them
  ome_row_type rows [10] = '{
    '{14'h3091, 8'h00, 8'h91, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0},
    '{14'h0405, 8'h13, 8'h93, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0},
    '{14'h0485, 8'h13, 8'h93, 1'h0, 1'h1, 8'h93, 1'h1, 1'h0},
    '{14'h08ff, 8'h00, 8'h93, 1'h1, 1'h1, 8'h00, 1'h1, 1'h0},
    '{14'h3300, 8'h00, 8'h00, 1'h1, 1'h0, 8'h00, 1'h1, 1'h0},
    '{14'h0800, 8'h5a, 8'h5a, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0},
    '{14'h3200, 8'h00, 8'h00, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0},
    '{14'h0400, 8'h00, 8'h00, 1'h1, 1'h0, 8'h00, 1'h1, 1'h0},
    '{14'h08c0, 8'h80, 8'h00, 1'h0, 1'h1, 8'h80, 1'h1, 1'h0},
    '{14'h3800, 8'hff, 8'h00, 1'h0, 1'h0, 8'h00, 1'h0, 1'h1}
  };

  ome_exec i_dut (
    .clock(clock),
    .arst_n(arst_n),
    .enable(enable),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_rdata(file_rdata),
    .w(w),
    .zero(zero),
    .file_wr(file_wr),
    .done(done),
    .other(other)
  );

  initial forever #20 clock = ~clock;

  // address and data only matter while the write strobe is up
  function automatic logic [31:0] outs();
    return {5'h00, w, zero, file_wr.en,
      file_wr.en ? {file_wr.addr, file_wr.data} : 15'h0000, done, other};
  endfunction : outs

  function automatic logic [31:0] want(input ome_row_type r);
    return {5'h00, r.w, r.z, r.e, r.e ? {r.i[6:0], r.d} : 15'h0000,
      r.dn, r.o};
  endfunction : want

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string nm);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    ome_row_type hand;
    repeat (8) @(posedge clock);
    #1 chk(outs(), 32'h0, "reset");
    arst_n = 1'h1;
    instr_valid = 1'h1;
    foreach (rows[k]) begin
      instr = rows[k].i;
      file_rdata = rows[k].f;
      @(posedge clock);
      #1 chk(outs(), want(rows[k]), "row");
    end
    // a frozen cycle must not take the literal, nor drop the pulses
    instr = 14'h30a5;
    enable = 1'h0;
    @(posedge clock);
    #1 chk(outs(), want(rows[9]), "frozen");
    enable = 1'h1;
    instr_valid = 1'h0;
    @(posedge clock);
    #1 chk(outs(), 32'h0, "idle");
    // literal with bits 9:8 at 01, then a zero moved onto itself
    instr = 14'h315a;
    instr_valid = 1'h1;
    @(posedge clock);
    #1 instr = 14'h08ff;
    file_rdata = 8'h00;
    @(posedge clock);
    hand = '{14'h08ff, 8'h00, 8'h5a, 1'h1, 1'h1, 8'h00, 1'h1, 1'h0};
    #1 chk(outs(), want(hand), "busy");
    // mid-run reset with state set and a write pulse standing
    arst_n = 1'h0;
    #1 chk(outs(), 32'h0, "second reset");
    @(posedge clock);
    #1 arst_n = 1'h1;
    hand.w = 8'h00;
    @(posedge clock);
    #1 chk(outs(), want(hand), "after reset");
    complete_run();
  end
endmodule : ome_exec_tb_top
